// >>> rtl/qdsp_map.svh
// constants of the quad converter serial input port
`ifndef QDSP_MAP_SVH
`define QDSP_MAP_SVH
`define QDSP_WORD_BITS 16
`define QDSP_CNT_W 5
`define QDSP_SCLK_MAX_KHZ 30000
`define QDSP_SYS_CLK_KHZ 10000
`endif

// >>> rtl/qdsp_pkg.sv
// types of the quad converter serial input port
package qdsp_pkg;
	typedef struct packed {
		logic sync_n;
		logic sclk;
		logic din;
	} qdsp_pins_s;
	typedef struct packed {
		logic [15:0] data;
		logic valid;
	} qdsp_word_s;
	typedef enum logic [1:0] {
		QDSP_IDLE,
		QDSP_SHIFT,
		QDSP_DONE
	} qdsp_state_e;
endpackage

// >>> rtl/qdsp_serial_port.sv
// serial input port: collects one 16-bit word per frame
`timescale 1ns/1ps
`include "qdsp_map.svh"

// Notes on behaviour
// [RULE1] the input shift register is exactly sixteen bits wide
// [RULE2] data is sampled on each falling serial clock edge within a frame
// [RULE3] host keeps serial clock at or below 30 MHz
// [RULE4] input buffers are powered down after every completed write
// [RULE5] frame select low opens a frame; next sixteen falling edges taken
// [RULE6] frame select high before sixteenth edge aborts and drops the word
// [RULE7] after sixteen bits, further edges ignored until frame reopens
module qdsp_serial_port (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// serial pins
	input wire qdsp_pkg::qdsp_pins_s pins_i,
	// received word
	output qdsp_pkg::qdsp_word_s word_o,
	output logic buf_en_o,
	output logic abort_o
);
	import qdsp_pkg::*;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	qdsp_pins_s meta_q;
	qdsp_pins_s sync_q;
	logic sclk_prev_q;
	logic sync_n_prev_q;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			// clock history starts at the idle level: no false edge
			meta_q <= '{sync_n: 1'b1, sclk: 1'b1, din: 1'b0};
			sync_q <= '{sync_n: 1'b1, sclk: 1'b1, din: 1'b0};
			sclk_prev_q <= 1'b1;
			sync_n_prev_q <= 1'b1;
		end else begin
			meta_q <= pins_i;
			sync_q <= meta_q;
			sclk_prev_q <= sync_q.sclk;
			sync_n_prev_q <= sync_q.sync_n;
		end
	end

	logic sclk_fall;
	logic frame_open;
	logic frame_close;
	assign sclk_fall = sclk_prev_q & ~sync_q.sclk;
	assign frame_open = sync_n_prev_q & ~sync_q.sync_n;
	assign frame_close = ~sync_n_prev_q & sync_q.sync_n;

	// ************************************************************
	// helpers
	// ************************************************************
	// true when the count points at the last bit of a word
	function automatic logic is_last_bit(input logic [`QDSP_CNT_W-1:0] c);
		return c == 5'(`QDSP_WORD_BITS - 1);
	endfunction

	// ************************************************************
	// frame control and shifting
	// ************************************************************
	qdsp_state_e state_q;
	logic [`QDSP_WORD_BITS-1:0] shift_q;
	logic [`QDSP_CNT_W-1:0] cnt_q;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= QDSP_IDLE;
			shift_q <= '0;
			cnt_q <= '0;
		end else begin
			case (state_q)
				QDSP_IDLE: begin
					if (frame_open) begin // RULE5
						state_q <= QDSP_SHIFT;
						cnt_q <= '0;
					end
				end
				QDSP_SHIFT: begin
					if (frame_close) begin // RULE6
						state_q <= QDSP_IDLE;
					end else if (sclk_fall) begin // RULE2
						shift_q <= {shift_q[`QDSP_WORD_BITS-2:0],
							sync_q.din}; // RULE1
						cnt_q <= cnt_q + 5'h01;
						if (is_last_bit(cnt_q)) begin
							state_q <= QDSP_DONE; // RULE5
						end
					end
				end
				QDSP_DONE: begin
					if (frame_close) begin // RULE7
						state_q <= QDSP_IDLE;
					end
				end
				default: state_q <= QDSP_IDLE;
			endcase
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	// a close seen with the last bit counts as a cut: abort wins
	logic done_now;
	assign done_now = (state_q == QDSP_SHIFT) && !frame_close && sclk_fall
		&& is_last_bit(cnt_q);

	// received word and its one-cycle strobe
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			word_o <= '0;
		end else begin
			word_o.valid <= done_now;
			if (done_now) begin
				word_o.data <= {shift_q[`QDSP_WORD_BITS-2:0], sync_q.din};
			end
		end
	end

	// one-cycle flag for a frame cut short
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			abort_o <= 1'b0;
		end else begin
			abort_o <= (state_q == QDSP_SHIFT) && frame_close; // RULE6
		end
	end

	// input buffers powered from frame open until done or close
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			buf_en_o <= 1'b0;
		end else if (frame_open && state_q == QDSP_IDLE) begin
			buf_en_o <= 1'b1; // RULE5
		end else if (done_now || frame_close) begin
			buf_en_o <= 1'b0; // RULE4
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_open;
		(state_q == QDSP_IDLE) && frame_open;
	endsequence

	sequence s_bit_taken;
		(state_q == QDSP_SHIFT) && !frame_close && sclk_fall;
	endsequence

	sequence s_cut;
		(state_q == QDSP_SHIFT) && frame_close;
	endsequence

	chk_open_shift: assert property (@(posedge sys_clk_i) // RULE5
		disable iff (!arst_n_i) s_open |=> state_q == QDSP_SHIFT)
		else $error("frame open did not start shifting");
	chk_abort_pulse: assert property (@(posedge sys_clk_i) // RULE6
		disable iff (!arst_n_i)
		(state_q == QDSP_SHIFT && frame_close) |=> abort_o && !word_o.valid)
		else $error("abort not flagged");
	chk_done_valid: assert property (@(posedge sys_clk_i) // RULE1
		disable iff (!arst_n_i) done_now |=> word_o.valid
		&& state_q == QDSP_DONE)
		else $error("word not delivered after sixteen bits");
	chk_buf_off: assert property (@(posedge sys_clk_i) // RULE4
		disable iff (!arst_n_i) word_o.valid |-> !buf_en_o)
		else $error("buffers still on after write");
	chk_done_hold: assert property (@(posedge sys_clk_i) // RULE7
		disable iff (!arst_n_i)
		(state_q == QDSP_DONE && !frame_close) |=> state_q == QDSP_DONE
		&& $stable(word_o.data))
		else $error("extra edges changed a finished frame");
	chk_shift_edge: assert property (@(posedge sys_clk_i) // RULE2
		disable iff (!arst_n_i)
		(state_q == QDSP_SHIFT && !sclk_fall) |=> $stable(cnt_q))
		else $error("bit counted without a falling edge");
	chk_idle_quiet: assert property (@(posedge sys_clk_i) // RULE5
		disable iff (!arst_n_i)
		(state_q == QDSP_IDLE && !frame_open) |=> state_q == QDSP_IDLE)
		else $error("left idle without frame open");
	chk_valid_pulse: assert property (@(posedge sys_clk_i) // RULE1
		disable iff (!arst_n_i) word_o.valid |=> !word_o.valid)
		else $error("valid held longer than one cycle");
	chk_bit_shift: assert property (@(posedge sys_clk_i) // RULE2
		disable iff (!arst_n_i)
		s_bit_taken |=> shift_q[0] == $past(sync_q.din)
		&& cnt_q == $past(cnt_q) + 5'h01)
		else $error("sampled bit not shifted in");
	chk_cut_keeps: assert property (@(posedge sys_clk_i) // RULE6
		disable iff (!arst_n_i)
		s_cut |=> state_q == QDSP_IDLE && $stable(word_o.data))
		else $error("cut frame changed the word");
	chk_data_strobe: assert property (@(posedge sys_clk_i) // RULE6
		disable iff (!arst_n_i) $changed(word_o.data) |-> word_o.valid)
		else $error("word changed without a strobe");
	chk_buf_open: assert property (@(posedge sys_clk_i) // RULE5
		disable iff (!arst_n_i) s_open |=> buf_en_o)
		else $error("buffers not powered at frame open");
	chk_buf_close: assert property (@(posedge sys_clk_i) // RULE4
		disable iff (!arst_n_i) frame_close |=> !buf_en_o)
		else $error("buffers still on after frame close");
	chk_count_bound: assert property (@(posedge sys_clk_i) // RULE1
		disable iff (!arst_n_i) cnt_q <= 5'(`QDSP_WORD_BITS))
		else $error("bit count beyond word width");
	chk_done_close: assert property (@(posedge sys_clk_i) // RULE7
		disable iff (!arst_n_i)
		(state_q == QDSP_DONE && frame_close) |=> state_q == QDSP_IDLE
		&& !abort_o)
		else $error("finished frame close mishandled");
endmodule

// >>> testbench/qdsp_host_model.sv
// host side model that drives the three serial pins
`timescale 1ns/1ps
module qdsp_host_model (
	// clock
	input wire logic sys_clk_i,
	// serial pins
	output qdsp_pkg::qdsp_pins_s pins_o
);
	import qdsp_pkg::*;
	initial pins_o = 3'h6;
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	// n falls, msb first; sclk idles high, 800 ns period
	task automatic send(input logic [19:0] d, input int n);
		tick(1);
		pins_o.sync_n = 1'b0;
		for (int i = 19; i > 19 - n; i--) begin
			pins_o.din = d[i];
			tick(4);
			pins_o.sclk = 1'b0;
			tick(4);
			pins_o.sclk = 1'b1;
		end
		tick(4);
		pins_o.sync_n = 1'b1;
		pins_o.din = ~pins_o.din;
		tick(4);
	endtask
endmodule

// >>> testbench/testbench.sv
// self-checking bench of the serial input port
`timescale 1ns/1ps
module testbench;
	import qdsp_pkg::*;
	logic sys_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	qdsp_pins_s pins;
	qdsp_word_s word;
	logic buf_en;
	logic abort;
	logic [15:0] last = 16'h0000;
	logic [16:0] exp_q[$];
	int fail_count = 0;
	int cmp_count = 0;
	qdsp_host_model qdsp_host_model_i (.sys_clk_i(sys_clk_i), .pins_o(pins));
	qdsp_serial_port qdsp_serial_port_i (.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i), .pins_i(pins), .word_o(word),
		.buf_en_o(buf_en), .abort_o(abort));
	initial forever #50 sys_clk_i = ~sys_clk_i;
	task automatic chk(input string nm, input logic [16:0] e,
		input logic [16:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_buf(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// results are matched against the oldest note
	always @(posedge sys_clk_i) begin
		#2;
		if (word.valid === 1'b1 || abort === 1'b1) begin
			if (exp_q.size() == 0) chk("extra", 17'h0, {1'b1, word.data});
			else chk("result", exp_q.pop_front(), {abort, word.data});
		end
		if (word.valid === 1'b1) chk_buf("buf_off", 1'b0, buf_en);
	end
	initial begin
		int n;
		logic [19:0] d;
		void'($urandom(32'h1a4b));
		fork
			begin
				#1000000;
				fail_count++;
				test_done();
			end
		join_none
		repeat (20) @(posedge sys_clk_i);
		#1 arst_n_i = 1'b1;
		repeat (4) @(posedge sys_clk_i);
		for (int k = 0; k < 9; k++) begin
			n = (k % 3 == 0) ? 16 : (k % 3 == 1) ? 20 : 15;
			d = 20'($urandom());
			if (n < 16) exp_q.push_back({1'b1, last});
			else begin
				last = d[19:4];
				exp_q.push_back({1'b0, last});
			end
			fork
				qdsp_host_model_i.send(d, n);
				begin
					repeat (12) @(posedge sys_clk_i);
					#2 chk_buf("buf_on", 1'b1, buf_en);
				end
			join
			repeat (4) @(posedge sys_clk_i);
			#2 chk_buf("buf_idle", 1'b0, buf_en);
			$display("test %0d done with %0d falls", k, n);
		end
		chk("pending", 17'h0, 17'(exp_q.size()));
		test_done();
	end
endmodule
